// *** hdl/rbm_pkg.sv ***
// Package for the ring beacon monitor: register map, field layout, timing.
// Assumes a 10 MHz system clock and a 32-bit Wishbone data path.
package rbm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef logic [31:0] rbm_word_t;
    typedef logic [15:0] rbm_half_t;
    typedef logic [7:0] rbm_state_t;
    typedef logic [9:0] rbm_adr_t;
    typedef logic [7:0] rbm_idx_t;
    typedef logic [3:0] rbm_evt_t;

    ////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam int WORD_LSB = 2;
    localparam rbm_idx_t IDX_CTRL = 8'h6c;
    localparam rbm_idx_t IDX_STATE_PAIR = 8'h6e;
    localparam rbm_idx_t IDX_TMO_LO = 8'h70;
    localparam rbm_idx_t IDX_TMO_HI = 8'h72;
    localparam rbm_idx_t IDX_P1_TS_LO = 8'h74;
    localparam rbm_idx_t IDX_P1_TS_HI = 8'h76;
    localparam rbm_idx_t IDX_P2_TS_LO = 8'h78;
    localparam rbm_idx_t IDX_P2_TS_HI = 8'h7a;
    localparam rbm_idx_t IDX_EVT_STATUS = 8'h90;
    localparam rbm_idx_t IDX_EVT_MASK = 8'h92;

    ////////////////////////////////////////////////////////////////////////
    // Fields
    localparam int CTRL_P1_EN_BIT = 9;
    localparam int CTRL_P2_EN_BIT = 10;
    localparam int EVT_P1_CHG = 0;
    localparam int EVT_P2_CHG = 1;
    localparam int EVT_P1_LOSS = 2;
    localparam int EVT_P2_LOSS = 3;
    localparam int EVT_W = 4;
    localparam rbm_half_t HALF_RESET = 16'h0000;
    localparam rbm_word_t WORD_RESET = 32'h0000_0000;
    localparam rbm_state_t STATE_RESET = 8'h00;
    localparam rbm_evt_t EVT_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Timing: loss timers count at 50 MHz, clk runs at 10 MHz
    localparam int CLK_HZ = 10_000_000;
    localparam int TIMER_HZ = 50_000_000;
    localparam int TIMER_STEP = (TIMER_HZ + CLK_HZ - 1) / CLK_HZ;

endpackage

// *** hdl/rbm_port_if.sv ***
// Interface between the monitor top and one per-port beacon tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rbm_port_if;
    import rbm_pkg::*;
    logic beacon_seen;
    logic src_match;
    logic crc_err;
    rbm_state_t state_in;
    rbm_word_t free_time;
    logic enable;
    rbm_word_t reload;
    rbm_state_t captured_state;
    rbm_word_t arrival_time;
    rbm_word_t count;
    logic state_change_evt;
    logic loss_evt;

    modport top (
        output beacon_seen, src_match, crc_err, state_in, free_time,
        output enable, reload,
        input captured_state, arrival_time, count,
        input state_change_evt, loss_evt
    );
    modport tracker (
        input beacon_seen, src_match, crc_err, state_in, free_time,
        input enable, reload,
        output captured_state, arrival_time, count,
        output state_change_evt, loss_evt
    );
endinterface

// *** hdl/rbm_port_tracker.sv ***
// Per-port beacon tracker: state capture, timestamp and loss timer.
// Assumes beacon inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module rbm_port_tracker (
    input wire logic clk,
    input wire logic rstn,
    rbm_port_if.tracker p
);
    import rbm_pkg::*;

    localparam rbm_word_t STEP = rbm_word_t'(TIMER_STEP);

    logic en_q;
    logic hit;
    logic hit_ok;
    logic expire;

    assign hit = p.beacon_seen & p.src_match;
    assign hit_ok = hit & ~p.crc_err;
    assign expire = (p.count <= STEP);

    ////////////////////////////////////////////////////////////////////////
    // Capture of state and arrival time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p.captured_state <= STATE_RESET;
            p.arrival_time <= WORD_RESET;
            p.state_change_evt <= 1'b0;
        end else begin
            p.state_change_evt <= hit &&
                (p.state_in != p.captured_state);
            if (hit) begin
                p.captured_state <= p.state_in;
                p.arrival_time <= p.free_time;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loss timer, decremented by the 50 MHz ticks that fall in one clk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_q <= 1'b0;
            p.count <= WORD_RESET;
            p.loss_evt <= 1'b0;
        end else begin
            en_q <= p.enable;
            p.loss_evt <= 1'b0;
            if (!p.enable) begin
                p.count <= WORD_RESET;
            end else if (!en_q) begin
                p.count <= p.reload;
            end else if (hit_ok) begin
                p.count <= p.reload;
            end else if (expire) begin
                p.count <= p.reload;
                p.loss_evt <= 1'b1;
            end else begin
                p.count <= p.count - STEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_enable_loads: assert property (
        $rose(p.enable) |=> p.count == $past(p.reload))
        else $error("timer not loaded on enable");
    a_beacon_reload: assert property (
        p.enable && hit_ok |=> p.count == $past(p.reload))
        else $error("timer not reloaded on beacon");
    a_idle_off: assert property (
        !p.enable |=> p.count == WORD_RESET && !p.loss_evt)
        else $error("timer active while disabled");
    a_loss_on_expiry: assert property (
        p.enable && en_q && !hit_ok && expire |=>
        p.loss_evt && p.count == $past(p.reload))
        else $error("expiry did not raise loss event");
    a_loss_cause: assert property (
        p.loss_evt |-> $past(p.enable) && $past(en_q))
        else $error("loss event without enabled timer");
    a_count_step: assert property (
        p.enable && en_q && !hit_ok && !expire |=>
        p.count == $past(p.count) - STEP)
        else $error("timer did not step down");
    a_state_capture: assert property (
        hit |=> p.captured_state == $past(p.state_in) &&
        p.arrival_time == $past(p.free_time))
        else $error("beacon capture missed");
    a_change_event: assert property (
        p.state_change_evt |-> $past(hit) &&
        p.captured_state != $past(p.captured_state))
        else $error("state change event without change");

    c_loss: cover property (p.loss_evt);
    c_change: cover property (p.state_change_evt);
    c_beacon_holds: cover property (p.enable && hit_ok ##1 p.enable [*3]);

endmodule

// *** hdl/rbm_top.sv ***
// Ring beacon monitor top: two port trackers behind a Wishbone slave.
// Assumes classic single-cycle Wishbone and sync beacon inputs on clk.
//
// Summary of operation
// - A read-only word at 0x6e shows port 1 state in bits 7:0 and port 2 state in bits 15:8, zero from reset.
// - A port's state byte is taken only from beacons on that port whose source matches the supervisor.
// - Any change of the port 1 state byte sets the port 1 state-change event flag.
// - Any change of the port 2 state byte sets the port 2 state-change event flag.
// - One 32-bit reload value, written as two 16-bit halves with the low half at 0x70, serves both timers.
// - Each port's loss timer is a 32-bit down counter running at 50 MHz.
// - Setting a port's timer enable loads the reload value and starts the countdown.
// - A matching beacon without CRC error reloads that port's timer.
// - When a timer reaches zero it sets that port's loss event flag and reloads.
// - A matching beacon on port 1 copies the free-running timer into the port 1 timestamp at 0x74/0x76.
// - A matching beacon on port 2 copies the free-running timer into the port 2 timestamp at 0x78/0x7a.
// - Each timer runs only while its enable bit is set.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module rbm_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire rbm_pkg::rbm_adr_t wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire rbm_pkg::rbm_word_t wb_dat_i,
    output rbm_pkg::rbm_word_t wb_dat_o,
    output logic wb_ack_o,
    input wire logic port1_beacon_seen,
    input wire logic port1_src_match,
    input wire logic port1_crc_err,
    input wire rbm_pkg::rbm_state_t port1_beacon_state,
    input wire logic port2_beacon_seen,
    input wire logic port2_src_match,
    input wire logic port2_crc_err,
    input wire rbm_pkg::rbm_state_t port2_beacon_state,
    input wire rbm_pkg::rbm_word_t free_run_time,
    output logic irq
);
    import rbm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    rbm_port_if p1_if ();
    rbm_port_if p2_if ();

    logic req;
    logic rd_take;
    logic wr_fire;
    logic lane_lo;
    logic lane_hi;
    rbm_idx_t idx;
    rbm_word_t rd_word;
    rbm_word_t loss_reload_value;
    logic port1_loss_timer_en;
    logic port2_loss_timer_en;
    rbm_evt_t evt_status;
    rbm_evt_t evt_mask;
    rbm_evt_t evt_set;
    rbm_evt_t evt_clr;
    rbm_evt_t next_status;
    logic port1_state_change_evt;
    logic port2_state_change_evt;
    logic port1_beacon_loss_evt;
    logic port2_beacon_loss_evt;
    rbm_state_t port1_captured_state;
    rbm_state_t port2_captured_state;
    rbm_word_t port1_arrival_time;
    rbm_word_t port2_arrival_time;

    function automatic rbm_half_t merge16(
        input rbm_half_t old_v,
        input rbm_half_t new_v,
        input logic lo,
        input logic hi
    );
        rbm_half_t r;
        r = old_v;
        if (lo) begin
            r[7:0] = new_v[7:0];
        end
        if (hi) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Port trackers
    assign p1_if.beacon_seen = port1_beacon_seen;
    assign p1_if.src_match = port1_src_match;
    assign p1_if.crc_err = port1_crc_err;
    assign p1_if.state_in = port1_beacon_state;
    assign p1_if.free_time = free_run_time;
    assign p1_if.enable = port1_loss_timer_en;
    assign p1_if.reload = loss_reload_value;

    assign p2_if.beacon_seen = port2_beacon_seen;
    assign p2_if.src_match = port2_src_match;
    assign p2_if.crc_err = port2_crc_err;
    assign p2_if.state_in = port2_beacon_state;
    assign p2_if.free_time = free_run_time;
    assign p2_if.enable = port2_loss_timer_en;
    assign p2_if.reload = loss_reload_value;

    rbm_port_tracker u_port1 (
        .clk(clk),
        .rstn(rstn),
        .p(p1_if.tracker)
    );

    rbm_port_tracker u_port2 (
        .clk(clk),
        .rstn(rstn),
        .p(p2_if.tracker)
    );

    assign port1_captured_state = p1_if.captured_state;
    assign port2_captured_state = p2_if.captured_state;
    assign port1_arrival_time = p1_if.arrival_time;
    assign port2_arrival_time = p2_if.arrival_time;
    assign port1_state_change_evt = p1_if.state_change_evt;
    assign port2_state_change_evt = p2_if.state_change_evt;
    assign port1_beacon_loss_evt = p1_if.loss_evt;
    assign port2_beacon_loss_evt = p2_if.loss_evt;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request, writes on the ack
    assign req = wb_cyc_i & wb_stb_i;
    assign rd_take = req & ~wb_ack_o;
    assign wr_fire = req & wb_ack_o & wb_we_i;
    assign lane_lo = wb_sel_i[0];
    assign lane_hi = wb_sel_i[1];
    assign idx = wb_adr_i[$bits(rbm_adr_t)-1:WORD_LSB];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= rd_take;
        end
    end

    always_comb begin
        rd_word = WORD_RESET;
        case (idx)
            IDX_CTRL: begin
                rd_word[CTRL_P1_EN_BIT] = port1_loss_timer_en;
                rd_word[CTRL_P2_EN_BIT] = port2_loss_timer_en;
            end
            IDX_STATE_PAIR: begin
                rd_word[15:0] = {port2_captured_state,
                                 port1_captured_state};
            end
            IDX_TMO_LO: rd_word[15:0] = loss_reload_value[15:0];
            IDX_TMO_HI: rd_word[15:0] = loss_reload_value[31:16];
            IDX_P1_TS_LO: rd_word[15:0] = port1_arrival_time[15:0];
            IDX_P1_TS_HI: rd_word[15:0] = port1_arrival_time[31:16];
            IDX_P2_TS_LO: rd_word[15:0] = port2_arrival_time[15:0];
            IDX_P2_TS_HI: rd_word[15:0] = port2_arrival_time[31:16];
            IDX_EVT_STATUS: rd_word[EVT_W-1:0] = evt_status;
            IDX_EVT_MASK: rd_word[EVT_W-1:0] = evt_mask;
            default: rd_word = WORD_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= WORD_RESET;
        end else if (rd_take) begin
            wb_dat_o <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared reload value and timer enables
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loss_reload_value <= WORD_RESET;
        end else if (wr_fire) begin
            if (idx == IDX_TMO_LO) begin
                loss_reload_value[15:0] <= merge16(loss_reload_value[15:0],
                    wb_dat_i[15:0], lane_lo, lane_hi);
            end
            if (idx == IDX_TMO_HI) begin
                loss_reload_value[31:16] <= merge16(loss_reload_value[31:16],
                    wb_dat_i[15:0], lane_lo, lane_hi);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port1_loss_timer_en <= 1'b0;
            port2_loss_timer_en <= 1'b0;
        end else if (wr_fire && idx == IDX_CTRL && lane_hi) begin
            port1_loss_timer_en <= wb_dat_i[CTRL_P1_EN_BIT];
            port2_loss_timer_en <= wb_dat_i[CTRL_P2_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags: sticky, write one to clear, a new event wins
    always_comb begin
        evt_set = EVT_RESET;
        evt_set[EVT_P1_CHG] = port1_state_change_evt;
        evt_set[EVT_P2_CHG] = port2_state_change_evt;
        evt_set[EVT_P1_LOSS] = port1_beacon_loss_evt;
        evt_set[EVT_P2_LOSS] = port2_beacon_loss_evt;
        evt_clr = EVT_RESET;
        if (wr_fire && idx == IDX_EVT_STATUS && lane_lo) begin
            evt_clr = wb_dat_i[EVT_W-1:0];
        end
        next_status = (evt_status & ~evt_clr) | evt_set;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_status <= EVT_RESET;
        end else begin
            evt_status <= next_status;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_mask <= EVT_RESET;
        end else if (wr_fire && idx == IDX_EVT_MASK && lane_lo) begin
            evt_mask <= wb_dat_i[EVT_W-1:0];
        end
    end

    assign irq = |(evt_status & evt_mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack did not follow request");
    a_ack_idle: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    a_rdata_hold: assert property (!rd_take |=> $stable(wb_dat_o))
        else $error("read data changed outside a read");
    a_state_pair_read: assert property (
        rd_take && idx == IDX_STATE_PAIR |=> wb_dat_o == {16'h0000,
        $past(port2_captured_state), $past(port1_captured_state)})
        else $error("state pair read wrong");
    a_p1_change_flag: assert property (
        port1_state_change_evt |=> evt_status[EVT_P1_CHG])
        else $error("port 1 change flag not set");
    a_p2_change_flag: assert property (
        port2_state_change_evt |=> evt_status[EVT_P2_CHG])
        else $error("port 2 change flag not set");
    a_loss_flags: assert property (
        port1_beacon_loss_evt || port2_beacon_loss_evt |=>
        (evt_status[EVT_P1_LOSS] || !$past(port1_beacon_loss_evt)) &&
        (evt_status[EVT_P2_LOSS] || !$past(port2_beacon_loss_evt)))
        else $error("loss flag not set");
    a_status_clear: assert property (
        wr_fire && idx == IDX_EVT_STATUS && lane_lo &&
        wb_dat_i[EVT_P1_CHG] && !port1_state_change_evt |=>
        !evt_status[EVT_P1_CHG])
        else $error("port 1 change flag not cleared");
    a_status_hold: assert property (
        evt_set == EVT_RESET && !wr_fire |=> $stable(evt_status))
        else $error("event flags changed without cause");
    a_reload_write: assert property (
        wr_fire && idx == IDX_TMO_LO && wb_sel_i[1:0] == 2'b11 |=>
        loss_reload_value[15:0] == $past(wb_dat_i[15:0]))
        else $error("reload low half not written");
    a_reload_high: assert property (
        wr_fire && idx == IDX_TMO_HI && wb_sel_i[1:0] == 2'b11 |=>
        loss_reload_value[31:16] == $past(wb_dat_i[15:0]))
        else $error("reload high half not written");
    a_reload_hold: assert property (
        !wr_fire |=> $stable(loss_reload_value))
        else $error("reload value changed without a write");
    a_ctrl_write: assert property (
        wr_fire && idx == IDX_CTRL && lane_hi |=>
        port1_loss_timer_en == $past(wb_dat_i[CTRL_P1_EN_BIT]) &&
        port2_loss_timer_en == $past(wb_dat_i[CTRL_P2_EN_BIT]))
        else $error("timer enables not written");
    a_ctrl_hold: assert property (
        !(wr_fire && idx == IDX_CTRL) |=>
        $stable(port1_loss_timer_en) && $stable(port2_loss_timer_en))
        else $error("timer enables changed without a write");
    a_p1_ts_read: assert property (
        rd_take && idx == IDX_P1_TS_LO |=>
        wb_dat_o == {16'h0000, $past(port1_arrival_time[15:0])})
        else $error("port 1 timestamp read wrong");
    a_ts_read: assert property (
        rd_take && idx == IDX_P2_TS_HI |=>
        wb_dat_o == {16'h0000, $past(port2_arrival_time[31:16])})
        else $error("port 2 timestamp read wrong");

    c_irq: cover property (irq);
    c_clear: cover property (evt_status != EVT_RESET ##1 evt_status == EVT_RESET);

endmodule

// *** sim/rbm_ring_port_model.sv ***
// Model of one ring port receive path feeding beacon indications.
// Assumes the bench calls send from its main process, clocked by clk.
`timescale 1ns/1ps
module rbm_ring_port_model (
    input wire logic clk,
    output logic seen,
    output logic src_match,
    output logic crc_err,
    output rbm_pkg::rbm_state_t state
);
    import rbm_pkg::*;
    initial begin
        seen = 1'b0;
        src_match = 1'b0;
        crc_err = 1'b0;
        state = 8'h00;
    end
    // One-cycle beacon, qualifiers scrambled once it has passed
    task automatic send(input logic m, input logic c, input rbm_state_t s);
        @(posedge clk);
        seen <= 1'b1;
        src_match <= m;
        crc_err <= c;
        state <= s;
        @(posedge clk);
        seen <= 1'b0;
        src_match <= ~m;
        crc_err <= ~c;
        state <= ~s;
    endtask
endmodule

// *** sim/ring_beacon_monitor_bench.sv ***
// Bench for the ring beacon monitor: registers, capture, timers, irq.
// Assumes rbm_top and two port models share one 10 MHz clock.
`timescale 1ns/1ps
module ring_beacon_monitor_bench;
    import rbm_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    rbm_adr_t adr = 10'h000;
    logic [3:0] sel = 4'h0;
    rbm_word_t wdat = 32'h0;
    rbm_word_t rdat;
    logic ack;
    logic irq;
    logic [1:0] seen;
    logic [1:0] mat;
    logic [1:0] crc;
    rbm_state_t st1;
    rbm_state_t st2;
    rbm_word_t free_run = 32'h0001_ffc0;
    int n_fail = 0;
    int checks = 0;

    always #50 clk = ~clk;
    always @(posedge clk) free_run <= free_run + 32'h1;

    rbm_ring_port_model u_p1 (.clk(clk), .seen(seen[0]),
        .src_match(mat[0]), .crc_err(crc[0]), .state(st1));
    rbm_ring_port_model u_p2 (.clk(clk), .seen(seen[1]),
        .src_match(mat[1]), .crc_err(crc[1]), .state(st2));
    rbm_top DUT (
        .clk(clk),
        .rstn(rstn),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .port1_beacon_seen(seen[0]),
        .port1_src_match(mat[0]),
        .port1_crc_err(crc[0]),
        .port1_beacon_state(st1),
        .port2_beacon_seen(seen[1]),
        .port2_src_match(mat[1]),
        .port2_crc_err(crc[1]),
        .port2_beacon_state(st2),
        .free_run_time(free_run),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////
    // Bus cycles and comparison
    task automatic check(input rbm_word_t got, input rbm_word_t exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input rbm_idx_t idx,
                      input rbm_word_t d, output rbm_word_t q);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h3;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        if (i >= 50) check(32'h0, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input rbm_idx_t idx, input rbm_word_t d);
        rbm_word_t q;
        wb(1'b1, idx, d, q);
    endtask
    task automatic rd(input rbm_idx_t idx, input rbm_word_t exp);
        rbm_word_t q;
        wb(1'b0, idx, 32'h0, q);
        check(q, exp);
    endtask
    task automatic chk_irq(input logic exp);
        @(posedge clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        rbm_idx_t ro [5];
        ro = '{IDX_STATE_PAIR, IDX_P1_TS_LO, IDX_P1_TS_HI,
               IDX_P2_TS_LO, IDX_P2_TS_HI};
        foreach (ro[i]) begin
            rd(ro[i], 32'h0);
            wr(ro[i], 32'h0000_ffff);
            rd(ro[i], 32'h0);
        end
        rd(IDX_TMO_LO, 32'h0);
        wr(IDX_TMO_LO, 32'h0000_1234);
        wr(IDX_TMO_HI, 32'h0000_abcd);
        rd(IDX_TMO_LO, 32'h0000_1234);
        rd(IDX_TMO_HI, 32'h0000_abcd);
        wr(8'h10, 32'h0000_ffff);
        rd(8'h10, 32'h0);
    endtask
    task automatic t_state;
        u_p1.send(1'b1, 1'b0, 8'h5a);
        rd(IDX_STATE_PAIR, 32'h0000_005a);
        rd(IDX_EVT_STATUS, 32'h1);
        chk_irq(1'b0);
        wr(IDX_EVT_MASK, 32'h1);
        chk_irq(1'b1);
        u_p1.send(1'b0, 1'b0, 8'h33);
        rd(IDX_STATE_PAIR, 32'h0000_005a);
        wr(IDX_EVT_STATUS, 32'h1);
        chk_irq(1'b0);
        u_p1.send(1'b1, 1'b1, 8'h5a);
        rd(IDX_EVT_STATUS, 32'h0);
        u_p2.send(1'b1, 1'b0, 8'hc3);
        rd(IDX_STATE_PAIR, 32'h0000_c35a);
        rd(IDX_EVT_STATUS, 32'h2);
        wr(IDX_EVT_STATUS, 32'hf);
        wr(IDX_EVT_MASK, 32'h0);
    endtask
    task automatic t_stamp;
        rbm_word_t t;
        u_p1.send(1'b1, 1'b0, 8'h5a);
        t = free_run;
        rd(IDX_P1_TS_LO, {16'h0, t[15:0]});
        rd(IDX_P1_TS_HI, {16'h0, t[31:16]});
        rd(IDX_P1_TS_HI, {16'h0, t[31:16]});
        repeat (70) @(posedge clk);
        u_p2.send(1'b1, 1'b0, 8'hc3);
        t = free_run;
        rd(IDX_P2_TS_HI, {16'h0, t[31:16]});
        rd(IDX_P2_TS_LO, {16'h0, t[15:0]});
        rd(IDX_P2_TS_LO, {16'h0, t[15:0]});
    endtask
    task automatic t_timer;
        wr(IDX_TMO_LO, 32'd200);
        wr(IDX_TMO_HI, 32'h0);
        wr(IDX_CTRL, 32'h0200);
        rd(IDX_CTRL, 32'h0000_0200);
        repeat (24) @(posedge clk);
        rd(IDX_EVT_STATUS, 32'h0);
        repeat (24) @(posedge clk);
        rd(IDX_EVT_STATUS, 32'h4);
        wr(IDX_EVT_STATUS, 32'h4);
        repeat (44) @(posedge clk);
        rd(IDX_EVT_STATUS, 32'h4);
        u_p1.send(1'b1, 1'b0, 8'h5a);
        wr(IDX_EVT_STATUS, 32'h4);
        for (int i = 0; i < 4; i++) begin
            repeat (20) @(posedge clk);
            u_p1.send(1'b1, 1'b0, 8'h5a);
            rd(IDX_EVT_STATUS, 32'h0);
        end
        for (int i = 0; i < 3; i++) begin
            repeat (20) @(posedge clk);
            u_p1.send(1'b1, 1'b1, 8'h5a);
        end
        rd(IDX_EVT_STATUS, 32'h4);
        wr(IDX_CTRL, 32'h0);
        wr(IDX_EVT_STATUS, 32'hf);
        repeat (60) @(posedge clk);
        rd(IDX_EVT_STATUS, 32'h0);
        wr(IDX_CTRL, 32'h0600);
        repeat (50) @(posedge clk);
        rd(IDX_EVT_STATUS, 32'hc);
        wr(IDX_EVT_MASK, 32'h8);
        rd(IDX_EVT_MASK, 32'h8);
        chk_irq(1'b1);
        wr(IDX_EVT_MASK, 32'h0);
        chk_irq(1'b0);
        wr(IDX_CTRL, 32'h0);
        wr(IDX_TMO_HI, 32'h1);
        wr(IDX_EVT_STATUS, 32'hf);
        wr(IDX_CTRL, 32'h0200);
        repeat (60) @(posedge clk);
        rd(IDX_EVT_STATUS, 32'h0);
        wr(IDX_CTRL, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////
    // Run control
    task automatic print_verdict;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_state();
        t_stamp();
        t_timer();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
